// File: psi_consts.vh
`ifndef PSI_CONSTS_VH
`define PSI_CONSTS_VH

// ---------------------------------------------------------------
// Clock and bus timing
// ---------------------------------------------------------------
`define PSI_CLK_MHZ        250
`define PSI_STRETCH_US     1000
`define PSI_TIMEOUT_US     25000
`define PSI_CNT_W          24

// ---------------------------------------------------------------
// Addresses with the direction bit in bit 0; write form except alert response, which is read form; then the EEPROM offset and the filler byte
// ---------------------------------------------------------------
`define PSI_CTL_BASE       8'hb0
`define PSI_CTL_OPEN       8'hb6
`define PSI_EE_OFFSET      8'h10
`define PSI_ALERT_RESP     8'h19
`define PSI_IDLE_BYTE      8'hff

// ---------------------------------------------------------------
// Transfer limits and targets
// ---------------------------------------------------------------
`define PSI_BLOCK_MAX      9'h0ff
`define PSI_EE_LOC_IDX     9'h000
`define PSI_EE_DATA_IDX    9'h001
`define PSI_TGT_CTL        2'h0
`define PSI_TGT_EE         2'h1
`define PSI_TGT_ALERT      2'h2

`endif

// File: psi_eeprom.v
`timescale 1ns/1ns
module psi_eeprom #(
	parameter AW = 8,
	parameter DW = 8
) (
	input  wire          clk,
	input  wire          arst_n,
	input  wire          wr_en,
	input  wire          wr_protect,
	input  wire [AW-1:0] wr_addr,
	input  wire [DW-1:0] wr_data,
	input  wire [AW-1:0] rd_addr,
	output reg  [DW-1:0] rd_data
);

	reg [DW-1:0] mem [0:(1<<AW)-1];

	// ---------------------------------------------------------------
	// Storage, user bytes only; the supply never writes here itself.
	// ---------------------------------------------------------------
	always @(posedge clk)
	begin
		if (wr_en && !wr_protect)
			mem[wr_addr] <= wr_data;
	end

	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rd_data <= {DW{1'b0}};
		else
			rd_data <= mem[rd_addr];
	end

endmodule // psi_eeprom

// File: psi_master_model.sv
`timescale 1ns/1ns
module psi_master_model #(
	parameter HALF = 20
) (
	input  wire logic clk,
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_low,
	output logic      sda_low
);
	// ---------------------------------------------------------------
	// Bus master, timing compressed to keep the run short
	// ---------------------------------------------------------------
	initial
	begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end

	task automatic set(input logic c, input logic b);
		repeat (HALF) @(posedge clk);
		scl_low <= c;
		sda_low <= b;
	endtask

	// Also serves as repeated start, since data is released first.
	task automatic start();
		set(scl_low, 1'b0);
		set(1'b0, 1'b0);
		set(1'b0, 1'b1);
		set(1'b1, 1'b1);
	endtask

	task automatic stop();
		set(1'b1, 1'b1);
		set(1'b0, 1'b1);
		set(1'b0, 1'b0);
	endtask

	// Data changes only while the clock is low; a stretch is waited out, bounded.
	task automatic xbit(input logic b, output logic r);
		int n;
		n = 0;
		set(1'b1, !b);
		set(1'b0, !b);
		while (!scl && n < 4000)
		begin
			@(posedge clk);
			n++;
		end
		if (!scl)
		begin
			psi_smbus_slave_tb_top.mismatches++;
			$display("unexpected at %0t: clock stretch never ended", $time);
		end
		repeat (HALF) @(posedge clk);
		r = sda;
		scl_low <= 1'b1;
	endtask

	// Most significant bit first, ninth clock carries the acknowledge.
	task automatic wb(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			xbit(v[i], r);
		xbit(1'b1, r);
		ack = !r;
	endtask

	task automatic rb(input logic last, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--)
			xbit(1'b1, v[i]);
		xbit(last, r);
	endtask
endmodule // psi_master_model

// File: psi_smbus_slave.v
`timescale 1ns/1ns
`include "psi_consts.vh"
// Behaviour
// - Target only; never starts a transfer or drives a start condition.
// - Accepts the full 100 kbps clock; master must not go faster.
// - Any clock stretch by the device ends within 1 ms.
// - Clock low over 25 ms aborts transfer; interface ready within 10 ms.
// - Start and stop are seen anywhere and resynchronise the engine.
// - Alert output low while any shutdown or warning event is present.
// - Read at alert response address 0x19 returns the status byte.
// - Strap selects controller/EEPROM pairs B0/A0, B2/A2, B4/A4, B6/A6.
// - Unconnected strap gives controller B6 and EEPROM A6.
// - Strap sampled once after start-up and held until next start-up.
// - EEPROM address is always controller address minus fixed offset.
// - EEPROM writes blocked after reset until controller unprotects.
// - EEPROM holds 256 user bytes the supply never touches.
// - EEPROM read: address, location, repeated start, address read, byte.
// - Controller write may end after command, one or two data bytes.
// - Controller block writes up to 255 bytes after the command; block reads up to 256 bytes.
// - Controller read returns a byte or a word as the master clocks.
// - First byte holds seven address bits and direction in bit 0.
module psi_smbus_slave #(
	parameter NSHUT          = 4,
	parameter NWARN          = 4,
	parameter STRETCH_CYCLES = `PSI_STRETCH_US * `PSI_CLK_MHZ,
	parameter TIMEOUT_CYCLES = `PSI_TIMEOUT_US * `PSI_CLK_MHZ
) (
	input  wire             clk,
	input  wire             arst_n,
	input  wire             scl_i,
	output wire             scl_o,
	output reg              scl_oe,
	input  wire             sda_i,
	output wire             sda_o,
	output reg              sda_oe,
	input  wire [1:0]       address_select_strap,
	input  wire             strap_open,
	input  wire [NSHUT-1:0] shutdown_event,
	input  wire [NWARN-1:0] warning_event,
	output reg              fault_alert_line_n,
	input  wire [7:0]       status_byte,
	input  wire             eeprom_unprotect,
	output reg              ctl_wr_valid,
	output reg  [7:0]       ctl_wr_data,
	output reg  [8:0]       ctl_wr_index,
	output reg              ctl_wr_end,
	output reg              ctl_rd_req,
	output reg  [7:0]       ctl_rd_cmd,
	output reg  [8:0]       ctl_rd_index,
	input  wire             ctl_rd_valid,
	input  wire [7:0]       ctl_rd_data,
	output reg  [7:0]       ctl_addr,
	output reg  [7:0]       ee_addr
);

	localparam ST_IDLE  = 3'h0;
	localparam ST_RX    = 3'h1;
	localparam ST_RXACK = 3'h2;
	localparam ST_TX    = 3'h3;
	localparam ST_TXACK = 3'h4;
	localparam ST_WAIT  = 3'h5;

	localparam [`PSI_CNT_W-1:0] STRETCH_MAX = STRETCH_CYCLES[`PSI_CNT_W-1:0];
	localparam [`PSI_CNT_W-1:0] TIMEOUT_MAX = TIMEOUT_CYCLES[`PSI_CNT_W-1:0];

	// ---------------------------------------------------------------
	// Pin conditioning
	// ---------------------------------------------------------------
	wire [1:0] pins;
	wire       scl;
	wire       sda;
	reg        scl_d_reg;
	reg        sda_d_reg;

	psi_sync #(.W(2)) u_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.din    ({scl_i, sda_i}),
		.dout   (pins)
	);

	assign scl = pins[1];
	assign sda = pins[0];
	// Open-drain pins only ever pull low.
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;

	wire start_det = scl && scl_d_reg && sda_d_reg && !sda;
	wire stop_det  = scl && scl_d_reg && !sda_d_reg && sda;
	wire scl_rise  = scl && !scl_d_reg;
	wire scl_fall  = !scl && scl_d_reg;

	// ---------------------------------------------------------------
	// Engine state
	// ---------------------------------------------------------------
	reg [2:0]            state_reg;
	reg [3:0]            bitcnt_reg;
	reg [7:0]            shift_reg;
	reg                  first_reg;
	reg                  rd_reg;
	reg [1:0]            tgt_reg;
	reg [8:0]            bytecnt_reg;
	reg [7:0]            ee_ptr_reg;
	reg [7:0]            ee_data_reg;
	reg                  ee_pend_reg;
	reg                  ee_we_reg;
	reg                  wp_reg;
	reg                  strap_done_reg;
	reg [`PSI_CNT_W-1:0] low_cnt_reg;
	reg [`PSI_CNT_W-1:0] str_cnt_reg;
	wire [7:0]           ee_rd_data;

	psi_eeprom #(.AW(8), .DW(8)) u_eeprom (
		.clk        (clk),
		.arst_n     (arst_n),
		.wr_en      (ee_we_reg),
		.wr_protect (wp_reg),
		.wr_addr    (ee_ptr_reg),
		.wr_data    (ee_data_reg),
		.rd_addr    (ee_ptr_reg),
		.rd_data    (ee_rd_data)
	);

	wire match_ctl = (shift_reg[7:1] == ctl_addr[7:1]);
	wire match_ee  = (shift_reg[7:1] == ee_addr[7:1]);
	wire match_ara = (shift_reg == `PSI_ALERT_RESP);

	// Loads the next byte to send; the controller path stretches the clock
	// because its answer comes from the management logic, not from here.
	task load_tx;
	begin
		bitcnt_reg <= 4'h0;
		if (tgt_reg == `PSI_TGT_CTL)
		begin
			state_reg    <= ST_WAIT;
			scl_oe       <= 1'b1;
			ctl_rd_req   <= 1'b1;
			ctl_rd_index <= bytecnt_reg;
			str_cnt_reg  <= {`PSI_CNT_W{1'b0}};
		end
		else
		begin
			state_reg <= ST_TX;
			if (tgt_reg == `PSI_TGT_EE)
			begin
				shift_reg  <= ee_rd_data;
				sda_oe     <= ~ee_rd_data[7];
				ee_ptr_reg <= ee_ptr_reg + 8'h01;
			end
			else
			begin
				shift_reg <= status_byte;
				sda_oe    <= ~status_byte[7];
			end
		end
		bytecnt_reg <= bytecnt_reg + 9'h001;
	end
	endtask

	// ---------------------------------------------------------------
	// Strap capture and alert
	// ---------------------------------------------------------------
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			strap_done_reg     <= 1'b0;
			ctl_addr           <= `PSI_CTL_OPEN;
			ee_addr            <= `PSI_CTL_OPEN - `PSI_EE_OFFSET;
			fault_alert_line_n <= 1'b1;
			wp_reg             <= 1'b1;
		end
		else
		begin
			fault_alert_line_n <= ~((|shutdown_event) | (|warning_event));
			wp_reg             <= ~eeprom_unprotect;
			if (!strap_done_reg)
			begin
				strap_done_reg <= 1'b1;
				if (strap_open)
				begin
					ctl_addr <= `PSI_CTL_OPEN;
					ee_addr  <= `PSI_CTL_OPEN - `PSI_EE_OFFSET;
				end
				else
				begin
					ctl_addr <= `PSI_CTL_BASE | {5'h00, address_select_strap, 1'b0};
					ee_addr  <= (`PSI_CTL_BASE | {5'h00, address_select_strap, 1'b0})
						- `PSI_EE_OFFSET;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Bus engine
	// ---------------------------------------------------------------
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			scl_d_reg    <= 1'b1;
			sda_d_reg    <= 1'b1;
			state_reg    <= ST_IDLE;
			bitcnt_reg   <= 4'h0;
			shift_reg    <= 8'h00;
			first_reg    <= 1'b0;
			rd_reg       <= 1'b0;
			tgt_reg      <= `PSI_TGT_CTL;
			bytecnt_reg  <= 9'h000;
			ee_ptr_reg   <= 8'h00;
			ee_data_reg  <= 8'h00;
			ee_pend_reg  <= 1'b0;
			ee_we_reg    <= 1'b0;
			low_cnt_reg  <= {`PSI_CNT_W{1'b0}};
			str_cnt_reg  <= {`PSI_CNT_W{1'b0}};
			scl_oe       <= 1'b0;
			sda_oe       <= 1'b0;
			ctl_wr_valid <= 1'b0;
			ctl_wr_data  <= 8'h00;
			ctl_wr_index <= 9'h000;
			ctl_wr_end   <= 1'b0;
			ctl_rd_req   <= 1'b0;
			ctl_rd_cmd   <= 8'h00;
			ctl_rd_index <= 9'h000;
		end
		else
		begin
			scl_d_reg    <= scl;
			sda_d_reg    <= sda;
			ctl_wr_valid <= 1'b0;
			ctl_wr_end   <= 1'b0;
			ctl_rd_req   <= 1'b0;
			ee_we_reg    <= 1'b0;
			if (scl)
				low_cnt_reg <= {`PSI_CNT_W{1'b0}};
			else if (low_cnt_reg != TIMEOUT_MAX)
				low_cnt_reg <= low_cnt_reg + 1'b1;

			if (!scl && low_cnt_reg == TIMEOUT_MAX)
			begin
				// Timeout drops the transfer at once, well inside the recovery time.
				state_reg   <= ST_IDLE;
				scl_oe      <= 1'b0;
				sda_oe      <= 1'b0;
				ee_pend_reg <= 1'b0;
			end
			else if (stop_det)
			begin
				state_reg   <= ST_IDLE;
				scl_oe      <= 1'b0;
				sda_oe      <= 1'b0;
				ee_pend_reg <= 1'b0;
				ee_we_reg   <= ee_pend_reg;
				if (!first_reg && !rd_reg && tgt_reg == `PSI_TGT_CTL && state_reg != ST_IDLE)
				begin
					ctl_wr_end   <= 1'b1;
					ctl_wr_index <= bytecnt_reg;
				end
			end
			else if (start_det && strap_done_reg)
			begin
				// A repeated start keeps the pointer and command of the write part.
				state_reg   <= ST_RX;
				bitcnt_reg  <= 4'h0;
				first_reg   <= 1'b1;
				scl_oe      <= 1'b0;
				sda_oe      <= 1'b0;
				ee_pend_reg <= 1'b0;
			end
			else
			begin
				case (state_reg)
				ST_RX:
				begin
					if (scl_rise)
					begin
						shift_reg  <= {shift_reg[6:0], sda};
						bitcnt_reg <= bitcnt_reg + 4'h1;
					end
					else if (scl_fall && bitcnt_reg == 4'h8)
					begin
						bitcnt_reg <= 4'h0;
						state_reg  <= ST_RXACK;
						sda_oe     <= 1'b1;
						if (first_reg)
						begin
							first_reg   <= 1'b0;
							rd_reg      <= shift_reg[0];
							bytecnt_reg <= 9'h000;
							if (match_ara)
								tgt_reg <= `PSI_TGT_ALERT;
							else if (match_ctl)
								tgt_reg <= `PSI_TGT_CTL;
							else if (match_ee)
								tgt_reg <= `PSI_TGT_EE;
							else
							begin
								state_reg <= ST_IDLE;
								sda_oe    <= 1'b0;
							end
						end
						else if (tgt_reg == `PSI_TGT_EE)
						begin
							bytecnt_reg <= bytecnt_reg + 9'h001;
							if (bytecnt_reg == `PSI_EE_LOC_IDX)
								ee_ptr_reg <= shift_reg;
							else if (bytecnt_reg == `PSI_EE_DATA_IDX)
							begin
								ee_data_reg <= shift_reg;
								ee_pend_reg <= 1'b1;
							end
							else
							begin
								state_reg <= ST_IDLE;
								sda_oe    <= 1'b0;
							end
						end
						else if (tgt_reg == `PSI_TGT_CTL && bytecnt_reg <= `PSI_BLOCK_MAX)
						begin
							bytecnt_reg  <= bytecnt_reg + 9'h001;
							ctl_wr_valid <= 1'b1;
							ctl_wr_data  <= shift_reg;
							ctl_wr_index <= bytecnt_reg;
							if (bytecnt_reg == 9'h000)
								ctl_rd_cmd <= shift_reg;
						end
						else
						begin
							state_reg <= ST_IDLE;
							sda_oe    <= 1'b0;
						end
					end
				end
				ST_RXACK:
				begin
					if (scl_fall)
					begin
						sda_oe <= 1'b0;
						if (rd_reg)
						begin
							bytecnt_reg <= 9'h000;
							load_tx;
						end
						else
							state_reg <= ST_RX;
					end
				end
				ST_WAIT:
				begin
					str_cnt_reg <= str_cnt_reg + 1'b1;
					if (ctl_rd_valid || str_cnt_reg == STRETCH_MAX)
					begin
						// Without an answer in time a filler byte is sent; the clock stays
						// held one cycle more so the first bit is set up before it rises.
						state_reg <= ST_TX;
						shift_reg <= ctl_rd_valid ? ctl_rd_data : `PSI_IDLE_BYTE;
						sda_oe    <= ctl_rd_valid ? ~ctl_rd_data[7] : 1'b0;
					end
				end
				ST_TX:
				begin
					scl_oe <= 1'b0;
					if (scl_fall)
					begin
						if (bitcnt_reg == 4'h7)
						begin
							sda_oe    <= 1'b0;
							state_reg <= ST_TXACK;
						end
						else
						begin
							shift_reg  <= {shift_reg[6:0], 1'b0};
							sda_oe     <= ~shift_reg[6];
							bitcnt_reg <= bitcnt_reg + 4'h1;
						end
					end
				end
				ST_TXACK:
				begin
					if (scl_rise && sda)
						state_reg <= ST_IDLE;
					else if (scl_fall && bytecnt_reg <= `PSI_BLOCK_MAX)
						load_tx;
					else if (scl_fall)
						state_reg <= ST_IDLE;
				end
				default:
				begin
					// Idle never drives the bus on its own initiative.
					scl_oe <= 1'b0;
					sda_oe <= 1'b0;
				end
				endcase
			end
		end
	end

endmodule // psi_smbus_slave

// File: psi_smbus_slave_asserts.sv
`timescale 1ns/1ns
`include "psi_consts.vh"
module psi_smbus_slave_asserts #(
	parameter NSHUT          = 4,
	parameter NWARN          = 4,
	parameter STRETCH_CYCLES = 250000,
	parameter TIMEOUT_CYCLES = 6250000
) (
	input wire logic             clk,
	input wire logic             arst_n,
	input wire logic             scl_i,
	input wire logic             scl_oe,
	input wire logic             sda_oe,
	input wire logic [NSHUT-1:0] shutdown_event,
	input wire logic [NWARN-1:0] warning_event,
	input wire logic             fault_alert_line_n,
	input wire logic             ctl_wr_valid,
	input wire logic             ctl_rd_valid,
	input wire logic [7:0]       ctl_addr,
	input wire logic [7:0]       ee_addr
);
	logic [31:0] hold_reg;
	logic [31:0] low_reg;
	logic [1:0]  up_reg;

	// ---------------------------------------------------------------
	// Counters for waits far longer than a repetition can unroll
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hold_reg <= 32'h0;
			low_reg  <= 32'h0;
			up_reg   <= 2'h0;
		end
		else
		begin
			hold_reg <= scl_oe ? hold_reg + 32'h1 : 32'h0;
			low_reg  <= scl_i ? 32'h0 : low_reg + 32'h1;
			up_reg   <= (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_line_moves;
		$changed(sda_oe) || $rose(scl_oe);
	endsequence
	sequence s_rd_answered;
		scl_oe && ctl_rd_valid;
	endsequence

	property p_target_only; s_line_moves |-> !scl_i; endproperty
	property p_alert_on; (|shutdown_event || |warning_event) |=> !fault_alert_line_n; endproperty
	property p_alert_off; !(|shutdown_event || |warning_event) |=> fault_alert_line_n; endproperty
	property p_stretch; hold_reg <= STRETCH_CYCLES + 8; endproperty
	property p_timeout; low_reg > TIMEOUT_CYCLES + 8 |-> !sda_oe && !scl_oe; endproperty
	property p_rd_release; s_rd_answered |=> ##1 !scl_oe; endproperty
	property p_data_setup; $fell(scl_oe) |-> $stable(sda_oe); endproperty
	property p_wr_pulse; ctl_wr_valid |=> !ctl_wr_valid; endproperty
	property p_ee_offset; ee_addr == ctl_addr - `PSI_EE_OFFSET; endproperty
	property p_ctl_pair; ctl_addr[7:3] == 5'h16 && !ctl_addr[0]; endproperty
	property p_addr_held; up_reg == 2'h3 |-> $stable(ctl_addr); endproperty

	a_target_only: assert property (p_target_only)
		else $error("bus line moved while clock high");
	a_alert_on: assert property (p_alert_on)
		else $error("alert not raised");
	a_alert_off: assert property (p_alert_off)
		else $error("alert not cleared");
	a_stretch: assert property (p_stretch)
		else $error("stretch too long");
	a_timeout: assert property (p_timeout)
		else $error("bus held after clock timeout");
	a_rd_release: assert property (p_rd_release)
		else $error("clock not released after answer");
	a_data_setup: assert property (p_data_setup)
		else $error("data moved as the stretched clock was released");
	a_wr_pulse: assert property (p_wr_pulse)
		else $error("write strobe too long");
	a_ee_offset: assert property (p_ee_offset)
		else $error("memory address off pair");
	a_ctl_pair: assert property (p_ctl_pair)
		else $error("controller address outside set");
	a_addr_held: assert property (p_addr_held)
		else $error("address moved after start-up");
endmodule // psi_smbus_slave_asserts

bind psi_smbus_slave psi_smbus_slave_asserts #(.NSHUT(NSHUT), .NWARN(NWARN),
	.STRETCH_CYCLES(STRETCH_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) psi_smbus_slave_asserts_i (
	.clk(clk), .arst_n(arst_n), .scl_i(scl_i), .scl_oe(scl_oe), .sda_oe(sda_oe),
	.shutdown_event(shutdown_event), .warning_event(warning_event),
	.fault_alert_line_n(fault_alert_line_n), .ctl_wr_valid(ctl_wr_valid),
	.ctl_rd_valid(ctl_rd_valid), .ctl_addr(ctl_addr), .ee_addr(ee_addr));

// File: psi_smbus_slave_tb_top.sv
`timescale 1ns/1ns
module psi_smbus_slave_tb_top;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [1:0]  strap = 2'h0;
	logic        strap_open = 1'b0;
	logic [3:0]  shut = 4'h0;
	logic [3:0]  warn = 4'h0;
	logic [7:0]  status = 8'h00;
	logic        unprot = 1'b0;
	logic        rd_valid = 1'b0;
	logic [7:0]  rd_data = 8'h00;
	wire         scl_oe, sda_oe, alert_n, wr_valid, wr_end, rd_req, m_scl, m_sda;
	wire  [7:0]  wr_data, rd_cmd, ctl_addr, ee_addr;
	wire  [8:0]  wr_index, rd_index;
	wire         scl = !(scl_oe || m_scl);
	wire         sda = !(sda_oe || m_sda);
	int          mismatches = 0;
	int          check_count = 0;
	int          cycles = 0;
	int          cnt = 0;
	int          rd_delay = 10;
	int          acks;
	logic [16:0] wq[$];
	logic [8:0]  ends[$];
	logic        a;
	logic [7:0]  d;

	always #2 clk = ~clk;

	psi_smbus_slave #(.STRETCH_CYCLES(50), .TIMEOUT_CYCLES(2000)) psi_smbus_slave_i (
		.clk(clk), .arst_n(arst_n), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda),
		.sda_o(), .sda_oe(sda_oe), .address_select_strap(strap), .strap_open(strap_open),
		.shutdown_event(shut), .warning_event(warn), .fault_alert_line_n(alert_n),
		.status_byte(status), .eeprom_unprotect(unprot), .ctl_wr_valid(wr_valid),
		.ctl_wr_data(wr_data), .ctl_wr_index(wr_index), .ctl_wr_end(wr_end),
		.ctl_rd_req(rd_req), .ctl_rd_cmd(rd_cmd), .ctl_rd_index(rd_index),
		.ctl_rd_valid(rd_valid), .ctl_rd_data(rd_data), .ctl_addr(ctl_addr), .ee_addr(ee_addr));
	psi_master_model psi_master_model_i (.clk(clk), .scl(scl), .sda(sda),
		.scl_low(m_scl), .sda_low(m_sda));

	// ---------------------------------------------------------------
	// Controller side: answers each read after rd_delay cycles
	// ---------------------------------------------------------------
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (wr_valid)
			wq.push_back({wr_index, wr_data});
		if (wr_end)
			ends.push_back(wr_index);
		if (rd_req)
			cnt <= rd_delay;
		else if (cnt > 0)
			cnt <= cnt - 1;
		if (rd_req)
			rd_data <= rd_cmd ^ rd_index[7:0];
		rd_valid <= (cnt == 1);
		if (cycles == 60000)
		begin
			mismatches++;
			test_done();
		end
	end

	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic do_reset(input logic [2:0] code);
		@(posedge clk);
		arst_n <= 1'b0;
		{strap_open, strap} <= code;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask

	task automatic send(input logic [7:0] q[$]);
		acks = 0;
		psi_master_model_i.start();
		foreach (q[i])
		begin
			psi_master_model_i.wb(q[i], a);
			acks += a;
		end
	endtask

	task automatic fetch(input logic [7:0] adr);
		psi_master_model_i.start();
		psi_master_model_i.wb(adr, a);
		psi_master_model_i.rb(1'b1, d);
		psi_master_model_i.stop();
	endtask

	task automatic test_strap();
		logic [7:0] e;
		for (int c = 0; c < 5; c++)
		begin
			do_reset(3'(c));
			e = (c == 4) ? 8'hb6 : 8'hb0 + 8'(2 * c);
			check(17'(ctl_addr), 17'(e));
			check(17'(ee_addr), 17'(e - 8'h10));
		end
		do_reset(3'h1);
		strap <= 2'h3;
		repeat (20) @(posedge clk);
		check(17'(ctl_addr), 17'h0b2);
		$display("test_strap done");
	endtask

	task automatic test_alert();
		for (int i = 0; i < 8; i++)
		begin
			{warn, shut} <= 8'h01 << i;
			repeat (3) @(posedge clk);
			check(17'(alert_n), 17'h0);
			{warn, shut} <= 8'h00;
			repeat (3) @(posedge clk);
			check(17'(alert_n), 17'h1);
		end
		$display("test_alert done");
	endtask

	task automatic test_eeprom();
		unprot <= 1'b1;
		send('{8'ha2, 8'hff, 8'h3c});
		psi_master_model_i.stop();
		check(17'(acks), 17'h3);
		repeat (200) @(posedge clk);
		unprot <= 1'b0;
		send('{8'ha2, 8'hff, 8'hc3, 8'h55});
		psi_master_model_i.stop();
		check(17'(acks), 17'h3);
		repeat (200) @(posedge clk);
		send('{8'ha2, 8'hff});
		fetch(8'ha3);
		check(17'(d), 17'h03c);
		$display("test_eeprom done");
	endtask

	task automatic test_ctl_write();
		logic [7:0] q[$];
		for (int n = 0; n < 3; n++)
		begin
			q = '{8'hb2, 8'h21, 8'h34, 8'h56};
			q = q[0:n + 1];
			wq.delete();
			ends.delete();
			send(q);
			psi_master_model_i.stop();
			repeat (20) @(posedge clk);
			check(17'(ends.size()), 17'h1);
			check(17'(ends[0]), 17'(n + 1));
			check(17'(wq.size()), 17'(n + 1));
			foreach (wq[i])
				check(wq[i], {9'(i), q[i + 1]});
		end
		$display("test_ctl_write done");
	endtask

	task automatic test_ctl_read();
		for (int k = 0; k < 2; k++)
		begin
			rd_delay <= k ? 200 : 10;
			send('{8'hb2, 8'h8b});
			psi_master_model_i.start();
			psi_master_model_i.wb(8'hb3, a);
			psi_master_model_i.rb(1'b0, d);
			check(17'(d), k ? 17'h0ff : 17'h08b);
			psi_master_model_i.rb(1'b1, d);
			check(17'(d), k ? 17'h0ff : 17'h08a);
			psi_master_model_i.stop();
		end
		$display("test_ctl_read done");
	endtask

	task automatic test_alert_resp();
		logic r;
		status <= 8'h5e;
		psi_master_model_i.start();
		repeat (3) psi_master_model_i.xbit(1'b1, r);
		fetch(8'h19);
		check(17'(d), 17'h05e);
		wq.delete();
		send('{8'h40, 8'h01});
		psi_master_model_i.stop();
		check(17'(acks), 17'h0);
		check(17'(wq.size()), 17'h0);
		$display("test_alert_resp done");
	endtask

	task automatic test_timeout();
		logic       r;
		logic [7:0] v;
		v = 8'hb2;
		// The clock is held low while the device drives its acknowledge.
		psi_master_model_i.start();
		for (int i = 7; i >= 0; i--)
			psi_master_model_i.xbit(v[i], r);
		repeat (100) @(posedge clk);
		check(17'(sda_oe), 17'h1);
		repeat (2000) @(posedge clk);
		check(17'({scl_oe, sda_oe}), 17'h0);
		psi_master_model_i.wb(8'h21, a);
		check(17'(a), 17'h0);
		psi_master_model_i.stop();
		fetch(8'h19);
		check(17'(d), 17'h05e);
		$display("test_timeout done");
	endtask

	initial
	begin
		test_strap();
		test_alert();
		test_eeprom();
		test_ctl_write();
		test_ctl_read();
		test_alert_resp();
		test_timeout();
		test_done();
	end
endmodule // psi_smbus_slave_tb_top

// File: psi_sync.v
`timescale 1ns/1ns
module psi_sync #(
	parameter W = 2
) (
	input  wire         clk,
	input  wire         arst_n,
	input  wire [W-1:0] din,
	output wire [W-1:0] dout
);

	genvar i;
	generate
		for (i = 0; i < W; i = i + 1)
		begin : g_bit
			reg s1_reg;
			reg s2_reg;
			reg s3_reg;
			reg out_reg;
			// A change is taken only once the second and third stage agree.
			always @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					s1_reg  <= 1'b1;
					s2_reg  <= 1'b1;
					s3_reg  <= 1'b1;
					out_reg <= 1'b1;
				end
				else
				begin
					s1_reg <= din[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg)
						out_reg <= s3_reg;
				end
			end
			assign dout[i] = out_reg;
		end
	endgenerate

endmodule // psi_sync
